// ---- include/cpbc_pkg.sv ----
// Package: register map, field positions and reset values of the codec path bypass bank
// Behaviour
// - Left highpass uses programmable coefficients when set
// - Right highpass uses programmable coefficients when set
// - Two-bit field picks digital or analog microphones
// - Programmable filter inserted only with DACs down
// - Bus error detector runs while control bit zero
// - Error status reads one, cleared by reading
// - Right bypass bits route line inputs to outputs
// - Left bypass bits route line inputs to outputs
// - Two-bit field selects DAC reference current boost
package cpbc_pkg;
    localparam int CPBC_ADDR_W = 7;
    localparam int CPBC_DATA_W = 8;
    localparam logic [6:0] CPBC_ADDR_ADC_PATH = 7'h6b;
    localparam logic [6:0] CPBC_ADDR_BYPASS = 7'h6c;
    localparam logic [6:0] CPBC_ADDR_DAC_CUR = 7'h6d;
    // Field positions of the ADC path register
    localparam int CPBC_LEFT_COEF_BIT = 7;
    localparam int CPBC_RIGHT_COEF_BIT = 6;
    localparam int CPBC_DECIM_LSB = 4;
    localparam int CPBC_FILT_PATH_BIT = 3;
    localparam int CPBC_DET_DIS_BIT = 2;
    localparam int CPBC_ERR_BIT = 0;
    // Field positions of the bypass register
    localparam int CPBC_BYP_R2_NEG = 7;
    localparam int CPBC_BYP_R2_POS = 6;
    localparam int CPBC_BYP_R1_NEG = 5;
    localparam int CPBC_BYP_R1_POS = 4;
    localparam int CPBC_BYP_L2_NEG = 3;
    localparam int CPBC_BYP_L2_POS = 2;
    localparam int CPBC_BYP_L1_NEG = 1;
    localparam int CPBC_BYP_L1_POS = 0;
    localparam int CPBC_DAC_CUR_LSB = 6;
    localparam logic [7:0] CPBC_RST_VAL = 8'h00;
    localparam logic [3:0] CPBC_BITS_PER_BYTE = 4'h8;

    typedef enum logic [1:0]
    {
        CPBC_MIC_DIG_DIG = 2'b00,
        CPBC_MIC_DIG_ANA = 2'b01,
        CPBC_MIC_ANA_DIG = 2'b10,
        CPBC_MIC_ANA_ANA = 2'b11
    } cpbc_mic_sel_t;

    typedef enum logic [1:0]
    {
        CPBC_IREF_DEFAULT = 2'b00,
        CPBC_IREF_PLUS50 = 2'b01,
        CPBC_IREF_RSVD = 2'b10,
        CPBC_IREF_PLUS100 = 2'b11
    } cpbc_iref_t;

    typedef enum logic [0:0]
    {
        CPBC_DET_IDLE = 1'b0,
        CPBC_DET_BYTE = 1'b1
    } cpbc_det_state_t;
endpackage

// ---- include/cpbc_det_if.sv ----
// Interface: link between register bank and control-bus error detector
`timescale 1ns/1ns
`default_nettype none
interface cpbc_det_if;
    logic enable;
    logic scl;
    logic sda;
    logic err_pulse;
    logic bus_reset;
    modport det (input enable, input scl, input sda, output err_pulse, output bus_reset);
    modport ctl (output enable, output scl, output sda, input err_pulse, input bus_reset);
endinterface
`default_nettype wire

// ---- verilog/cpbc_bus_err_det.sv ----
// Control-bus error detector: flags a start or stop seen inside a byte
`timescale 1ns/1ns
`default_nettype none
module cpbc_bus_err_det
(
    input wire logic i_clk,
    input wire logic i_arst_n,
    cpbc_det_if.det det
);
    import cpbc_pkg::*;

    cpbc_det_state_t state_r;
    logic scl_prev_r;
    logic sda_prev_r;
    logic [3:0] bit_cnt_r;
    logic err_r;
    logic start_cond;
    logic stop_cond;
    logic scl_rise;
    logic mid_byte;

    assign start_cond = det.scl && scl_prev_r && sda_prev_r && !det.sda;
    assign stop_cond = det.scl && scl_prev_r && !sda_prev_r && det.sda;
    assign scl_rise = det.scl && !scl_prev_r;
    assign mid_byte = (state_r == CPBC_DET_BYTE) && (bit_cnt_r != 4'h0)
        && (bit_cnt_r < CPBC_BITS_PER_BYTE);

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            scl_prev_r <= 1'b1;
            sda_prev_r <= 1'b1;
        end
        else
        begin
            scl_prev_r <= det.scl;
            sda_prev_r <= det.sda;
        end
    end

    // Bit position within the current byte; ninth edge is the acknowledge
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            state_r <= CPBC_DET_IDLE;
            bit_cnt_r <= 4'h0;
        end
        else if (!det.enable || err_r)
        begin
            state_r <= CPBC_DET_IDLE;
            bit_cnt_r <= 4'h0;
        end
        else
        begin
            case (state_r)
                CPBC_DET_IDLE:
                begin
                    if (start_cond)
                    begin
                        state_r <= CPBC_DET_BYTE;
                        bit_cnt_r <= 4'h0;
                    end
                end
                CPBC_DET_BYTE:
                begin
                    if (stop_cond)
                        state_r <= CPBC_DET_IDLE;
                    else if (start_cond)
                        bit_cnt_r <= 4'h0;
                    else if (scl_rise)
                        bit_cnt_r <= (bit_cnt_r == CPBC_BITS_PER_BYTE) ? 4'h0 : bit_cnt_r + 4'h1;
                end
                default:
                begin
                    state_r <= CPBC_DET_IDLE;
                end
            endcase
        end
    end

    // Error pulse also tells the bus front end to drop its transfer state
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            err_r <= 1'b0;
        else
            err_r <= det.enable && !err_r && mid_byte && (start_cond || stop_cond);
    end

    assign det.err_pulse = err_r;
    assign det.bus_reset = err_r;
endmodule
`default_nettype wire

// ---- verilog/cpbc_top.sv ----
// Codec path, bypass and DAC current control registers with bus error status
`timescale 1ns/1ns
`default_nettype none
module cpbc_top
(
    input wire logic I_SYS_CLK,
    input wire logic I_ARST_N,
    input wire logic I_PAGE1_ACTIVE,
    input wire logic [cpbc_pkg::CPBC_ADDR_W-1:0] I_REG_ADDR,
    input wire logic I_REG_WR,
    input wire logic I_REG_RD,
    input wire logic [cpbc_pkg::CPBC_DATA_W-1:0] I_REG_WDATA,
    input wire logic I_SCL,
    input wire logic I_SDA,
    input wire logic I_HPF_ENABLE,
    input wire logic I_DACS_POWERED_DOWN,
    output logic [cpbc_pkg::CPBC_DATA_W-1:0] O_REG_RDATA,
    output logic O_REG_RVALID,
    output logic O_LEFT_HPF_PROG_COEF,
    output logic O_RIGHT_HPF_PROG_COEF,
    output logic O_LEFT_ANALOG_MIC,
    output logic O_RIGHT_ANALOG_MIC,
    output logic O_ADC_PROG_FILTER_EN,
    output logic O_BUS_RECOVER,
    output logic O_BUS_ERR_STATUS,
    output logic [7:0] O_BYPASS_SW,
    output logic [1:0] O_DAC_IREF_BOOST
);
    import cpbc_pkg::*;

    cpbc_det_if det_link();

    logic [7:0] adc_path_r;
    logic [7:0] bypass_r;
    logic [7:0] dac_cur_r;
    logic bus_err_r;
    logic [1:0] scl_sync_r;
    logic [1:0] sda_sync_r;
    logic wr_adc;
    logic wr_byp;
    logic wr_dac;
    logic rd_adc;
    logic page0;
    cpbc_mic_sel_t mic_sel;
    cpbc_iref_t iref;

    function automatic logic hit(input logic [6:0] addr, input logic [6:0] target);
        hit = (addr == target);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Register access
    assign page0 = !I_PAGE1_ACTIVE;
    assign wr_adc = page0 && I_REG_WR && hit(I_REG_ADDR, CPBC_ADDR_ADC_PATH);
    assign wr_byp = page0 && I_REG_WR && hit(I_REG_ADDR, CPBC_ADDR_BYPASS);
    assign wr_dac = page0 && I_REG_WR && hit(I_REG_ADDR, CPBC_ADDR_DAC_CUR);
    assign rd_adc = page0 && I_REG_RD && hit(I_REG_ADDR, CPBC_ADDR_ADC_PATH);

    // Low two bits are read-only and never stored
    always_ff @(posedge I_SYS_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
            adc_path_r <= CPBC_RST_VAL;
        else if (wr_adc)
            adc_path_r <= {I_REG_WDATA[7:2], 2'b00};
    end

    always_ff @(posedge I_SYS_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
            bypass_r <= CPBC_RST_VAL;
        else if (wr_byp)
            bypass_r <= I_REG_WDATA;
    end

    // Reserved low bits kept as written; host keeps them zero
    always_ff @(posedge I_SYS_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
            dac_cur_r <= CPBC_RST_VAL;
        else if (wr_dac)
            dac_cur_r <= I_REG_WDATA;
    end

    // Sticky error; a new event in the read cycle survives the clear
    always_ff @(posedge I_SYS_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
            bus_err_r <= 1'b0;
        else if (det_link.err_pulse)
            bus_err_r <= 1'b1;
        else if (rd_adc)
            bus_err_r <= 1'b0;
    end

    always_ff @(posedge I_SYS_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            O_REG_RDATA <= 8'h00;
            O_REG_RVALID <= 1'b0;
        end
        else
        begin
            O_REG_RVALID <= I_REG_RD;
            if (!I_REG_RD || !page0)
                O_REG_RDATA <= 8'h00;
            else if (hit(I_REG_ADDR, CPBC_ADDR_ADC_PATH))
                O_REG_RDATA <= {adc_path_r[7:2], 1'b0, bus_err_r};
            else if (hit(I_REG_ADDR, CPBC_ADDR_BYPASS))
                O_REG_RDATA <= bypass_r;
            else if (hit(I_REG_ADDR, CPBC_ADDR_DAC_CUR))
                O_REG_RDATA <= dac_cur_r;
            else
                O_REG_RDATA <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Control-bus pin synchronisers and error detector
    always_ff @(posedge I_SYS_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            scl_sync_r <= 2'b11;
            sda_sync_r <= 2'b11;
        end
        else
        begin
            scl_sync_r <= {scl_sync_r[0], I_SCL};
            sda_sync_r <= {sda_sync_r[0], I_SDA};
        end
    end

    assign det_link.enable = !adc_path_r[CPBC_DET_DIS_BIT];
    assign det_link.scl = scl_sync_r[1];
    assign det_link.sda = sda_sync_r[1];

    cpbc_bus_err_det u_det
    (
        .i_clk(I_SYS_CLK),
        .i_arst_n(I_ARST_N),
        .det(det_link.det)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Datapath controls
    assign mic_sel = cpbc_mic_sel_t'(adc_path_r[CPBC_DECIM_LSB +: 2]);
    assign iref = cpbc_iref_t'(dac_cur_r[CPBC_DAC_CUR_LSB +: 2]);

    always_ff @(posedge I_SYS_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            O_LEFT_HPF_PROG_COEF <= 1'b0;
            O_RIGHT_HPF_PROG_COEF <= 1'b0;
            O_ADC_PROG_FILTER_EN <= 1'b0;
        end
        else
        begin
            O_LEFT_HPF_PROG_COEF <= I_HPF_ENABLE && adc_path_r[CPBC_LEFT_COEF_BIT];
            O_RIGHT_HPF_PROG_COEF <= I_HPF_ENABLE && adc_path_r[CPBC_RIGHT_COEF_BIT];
            O_ADC_PROG_FILTER_EN <= adc_path_r[CPBC_FILT_PATH_BIT] && I_DACS_POWERED_DOWN;
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            O_LEFT_ANALOG_MIC <= 1'b0;
            O_RIGHT_ANALOG_MIC <= 1'b0;
        end
        else
        begin
            case (mic_sel)
                CPBC_MIC_DIG_DIG: {O_LEFT_ANALOG_MIC, O_RIGHT_ANALOG_MIC} <= 2'b00;
                CPBC_MIC_DIG_ANA: {O_LEFT_ANALOG_MIC, O_RIGHT_ANALOG_MIC} <= 2'b01;
                CPBC_MIC_ANA_DIG: {O_LEFT_ANALOG_MIC, O_RIGHT_ANALOG_MIC} <= 2'b10;
                CPBC_MIC_ANA_ANA: {O_LEFT_ANALOG_MIC, O_RIGHT_ANALOG_MIC} <= 2'b11;
                default: {O_LEFT_ANALOG_MIC, O_RIGHT_ANALOG_MIC} <= 2'b00;
            endcase
        end
    end

    // Switch bit n closes the switch of register bit n; no short protection in hardware
    always_ff @(posedge I_SYS_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
            O_BYPASS_SW <= 8'h00;
        else
        begin
            O_BYPASS_SW[7:4] <= bypass_r[7:4];
            O_BYPASS_SW[3:0] <= bypass_r[3:0];
        end
    end

    // Reserved code falls back to the default current
    always_ff @(posedge I_SYS_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
            O_DAC_IREF_BOOST <= 2'b00;
        else
        begin
            case (iref)
                CPBC_IREF_DEFAULT: O_DAC_IREF_BOOST <= 2'b00;
                CPBC_IREF_PLUS50: O_DAC_IREF_BOOST <= 2'b01;
                CPBC_IREF_PLUS100: O_DAC_IREF_BOOST <= 2'b10;
                default: O_DAC_IREF_BOOST <= 2'b00;
            endcase
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
            O_BUS_RECOVER <= 1'b0;
        else
            O_BUS_RECOVER <= det_link.bus_reset;
    end

    assign O_BUS_ERR_STATUS = bus_err_r;
endmodule
`default_nettype wire

// ---- testbench/cpbc_properties.sv ----
// Checker: port-level properties of the codec path bypass bank
`timescale 1ns/1ns
`default_nettype none
module cpbc_properties
    import cpbc_pkg::*;
(
    input wire logic I_SYS_CLK,
    input wire logic I_ARST_N,
    input wire logic I_PAGE1_ACTIVE,
    input wire logic [6:0] I_REG_ADDR,
    input wire logic I_REG_WR,
    input wire logic I_REG_RD,
    input wire logic [7:0] I_REG_WDATA,
    input wire logic I_HPF_ENABLE,
    input wire logic I_DACS_POWERED_DOWN,
    input wire logic [7:0] O_REG_RDATA,
    input wire logic O_REG_RVALID,
    input wire logic O_LEFT_HPF_PROG_COEF,
    input wire logic O_RIGHT_HPF_PROG_COEF,
    input wire logic O_ADC_PROG_FILTER_EN,
    input wire logic O_BUS_RECOVER,
    input wire logic O_BUS_ERR_STATUS,
    input wire logic [7:0] O_BYPASS_SW,
    input wire logic [1:0] O_DAC_IREF_BOOST
);
    default clocking @(posedge I_SYS_CLK); endclocking
    default disable iff (!I_ARST_N);
    sequence s_rd_ctl;
        I_REG_RD && I_REG_ADDR == CPBC_ADDR_ADC_PATH && !I_PAGE1_ACTIVE;
    endsequence
    sequence s_wr_byp;
        I_REG_WR && I_REG_ADDR == CPBC_ADDR_BYPASS && !I_PAGE1_ACTIVE;
    endsequence
    property p_byp_wr;
        s_wr_byp |-> ##2 O_BYPASS_SW == $past(I_REG_WDATA, 2);
    endproperty
    a_byp_wr: assert property (p_byp_wr) else $error("bypass switches miss write");
    property p_rvalid;
        I_REG_RD |=> O_REG_RVALID;
    endproperty
    a_rvalid: assert property (p_rvalid) else $error("read gave no valid pulse");
    property p_err_clr;
        s_rd_ctl |=> O_BUS_ERR_STATUS == O_BUS_RECOVER && O_REG_RDATA[1] == 1'b0;
    endproperty
    a_err_clr: assert property (p_err_clr) else $error("status not cleared by read");
    property p_sticky;
        $fell(O_BUS_ERR_STATUS) |->
            $past(I_REG_RD && I_REG_ADDR == CPBC_ADDR_ADC_PATH && !I_PAGE1_ACTIVE);
    endproperty
    a_sticky: assert property (p_sticky) else $error("status fell without read");
    property p_rec_sets;
        O_BUS_RECOVER |-> O_BUS_ERR_STATUS ##1 !O_BUS_RECOVER;
    endproperty
    a_rec_sets: assert property (p_rec_sets) else $error("recover without status");
    property p_left;
        O_LEFT_HPF_PROG_COEF |-> $past(I_HPF_ENABLE);
    endproperty
    a_left: assert property (p_left) else $error("left coef with filter off");
    property p_right;
        O_RIGHT_HPF_PROG_COEF |-> $past(I_HPF_ENABLE);
    endproperty
    a_right: assert property (p_right) else $error("right coef with filter off");
    property p_filt;
        O_ADC_PROG_FILTER_EN |-> $past(I_DACS_POWERED_DOWN);
    endproperty
    a_filt: assert property (p_filt) else $error("filter inserted with DAC on");
    property p_iref;
        O_DAC_IREF_BOOST != 2'b11;
    endproperty
    a_iref: assert property (p_iref) else $error("illegal current boost");
    property p_rst;
        $rose(I_ARST_N) |-> O_BYPASS_SW == 8'h00 && O_DAC_IREF_BOOST == 2'b00;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
endmodule
bind cpbc_top cpbc_properties u_props (.I_SYS_CLK, .I_ARST_N, .I_PAGE1_ACTIVE, .I_REG_ADDR,
    .I_REG_WR, .I_REG_RD, .I_REG_WDATA, .I_HPF_ENABLE, .I_DACS_POWERED_DOWN, .O_REG_RDATA,
    .O_REG_RVALID, .O_LEFT_HPF_PROG_COEF, .O_RIGHT_HPF_PROG_COEF, .O_ADC_PROG_FILTER_EN,
    .O_BUS_RECOVER, .O_BUS_ERR_STATUS, .O_BYPASS_SW, .O_DAC_IREF_BOOST);
`default_nettype wire

// ---- testbench/cpbc_host_model.sv ----
// Host model: drives the control-bus pins, driven high directly at idle
`timescale 1ns/1ns
`default_nettype none
module cpbc_host_model
(
    input wire logic i_clk,
    output logic o_scl,
    output logic o_sda
);
    initial
    begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end
    task automatic hold;
        repeat (4) @(posedge i_clk);
        #10;
    endtask
    // Start, three clocked bits, then a stop inside the byte
    task automatic bad_frame;
        o_sda = 1'b0;
        hold();
        for (int k = 0; k < 3; k++)
        begin
            o_scl = 1'b0;
            hold();
            o_sda = k[0];
            hold();
            o_scl = 1'b1;
            hold();
        end
        o_sda = 1'b1;
        hold();
    endtask
endmodule
`default_nettype wire

// ---- testbench/tb.sv ----
// Testbench: register bank checks with a control-bus host model
`timescale 1ns/1ns
`default_nettype none
module tb;
    import cpbc_pkg::*;
    logic clk = 0, arst_n = 0, page1 = 0, wr = 0, rd = 0, highpass_filter = 0, dacs = 0;
    logic scl, sda, rv, lc, rc, lm, rm, pf, rec, err;
    logic [6:0] addr = 7'h00;
    logic [7:0] wd = 8'h00, rdat, byp, d;
    logic [1:0] iref;
    int fails = 0, check_count = 0, seed = 96, i, rec_seen = 0;
    cpbc_host_model u_host (.i_clk(clk), .o_scl(scl), .o_sda(sda));
    cpbc_top u_dut (.I_SYS_CLK(clk), .I_ARST_N(arst_n), .I_PAGE1_ACTIVE(page1),
        .I_REG_ADDR(addr), .I_REG_WR(wr), .I_REG_RD(rd), .I_REG_WDATA(wd), .I_SCL(scl),
        .I_SDA(sda), .I_HPF_ENABLE(highpass_filter), .I_DACS_POWERED_DOWN(dacs), .O_REG_RDATA(rdat),
        .O_REG_RVALID(rv), .O_LEFT_HPF_PROG_COEF(lc), .O_RIGHT_HPF_PROG_COEF(rc),
        .O_LEFT_ANALOG_MIC(lm), .O_RIGHT_ANALOG_MIC(rm), .O_ADC_PROG_FILTER_EN(pf),
        .O_BUS_RECOVER(rec), .O_BUS_ERR_STATUS(err), .O_BYPASS_SW(byp), .O_DAC_IREF_BOOST(iref));
    initial
    begin
        forever #50 clk = ~clk;
    end
    // Counts recovery pulses, one per detected bus error
    always @(posedge clk)
    begin
        if (rec === 1'b1)
            rec_seen++;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #10;
    endtask
    task automatic wr_reg(input logic [6:0] a, input logic [7:0] v);
        addr = a;
        wd = v;
        wr = 1'b1;
        cyc(1);
        wr = 1'b0;
        cyc(1);
    endtask
    task automatic rd_reg(input logic [6:0] a, input logic [7:0] exp);
        addr = a;
        rd = 1'b1;
        cyc(1);
        rd = 1'b0;
        chk({7'h0, rv}, 8'h01);
        chk(rdat, exp);
        cyc(1);
    endtask
    function automatic logic [1:0] exp_iref(input logic [1:0] c);
        return (c == 2'b11) ? 2'b10 : (c == 2'b10) ? 2'b00 : c;
    endfunction
    task automatic conclude;
        $display("fails=%0d check_count=%0d", fails, check_count);
        if (fails == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        cyc(5);
        arst_n = 1'b1;
        cyc(1);
        chk(byp, 8'h00);
        chk({iref, lc, rc, lm, rm, pf, err}, 8'h00);
        for (i = 0; i < 3; i++)
            rd_reg(7'(CPBC_ADDR_ADC_PATH + i), 8'h00);
        for (i = 0; i < 16; i++)
        begin
            d = (i == 0) ? 8'hcc : (i == 1) ? 8'h33 : 8'($random(seed));
            d = d & ~((d & 8'h33) << 2);
            wr_reg(CPBC_ADDR_BYPASS, d);
            chk(byp, d);
            rd_reg(CPBC_ADDR_BYPASS, d);
        end
        for (i = 0; i < 16; i++)
        begin
            d = 8'($random(seed)) & 8'hfc;
            d[5:4] = i[1:0];
            highpass_filter = 1'($random(seed));
            dacs = i[2];
            wr_reg(CPBC_ADDR_ADC_PATH, d);
            chk({3'h0, lc, rc, lm, rm, pf}, {3'h0, highpass_filter & d[7], highpass_filter & d[6], d[5:4], d[3] & dacs});
            rd_reg(CPBC_ADDR_ADC_PATH, d);
        end
        for (i = 0; i < 4; i++)
        begin
            d = {i[1:0], 6'h00};
            wr_reg(CPBC_ADDR_DAC_CUR, d);
            chk({6'h0, iref}, {6'h0, exp_iref(i[1:0])});
            rd_reg(CPBC_ADDR_DAC_CUR, d);
        end
        wr_reg(CPBC_ADDR_BYPASS, 8'h81);
        page1 = 1'b1;
        wr_reg(CPBC_ADDR_BYPASS, 8'h5a);
        chk(byp, 8'h81);
        rd_reg(CPBC_ADDR_BYPASS, 8'h00);
        page1 = 1'b0;
        rd_reg(7'h6e, 8'h00);
        wr_reg(CPBC_ADDR_ADC_PATH, 8'h00);
        u_host.bad_frame();
        for (i = 0; i < 60 && err !== 1'b1; i++)
            cyc(1);
        chk({7'h0, err}, 8'h01);
        cyc(20);
        chk({7'h0, err}, 8'h01);
        chk(8'(rec_seen), 8'h01);
        rd_reg(CPBC_ADDR_ADC_PATH, 8'h01);
        rd_reg(CPBC_ADDR_ADC_PATH, 8'h00);
        wr_reg(CPBC_ADDR_ADC_PATH, 8'h04);
        u_host.bad_frame();
        cyc(40);
        chk({7'h0, err}, 8'h00);
        chk(8'(rec_seen), 8'h01);
        rd_reg(CPBC_ADDR_ADC_PATH, 8'h04);
        conclude();
    end
endmodule
`default_nettype wire
